// File: sfhc_top.sv
/*
 * Status, fault and heating control block. Builds the operating and error
 * status bytes, detects stale measurements, forces analog and telegram
 * outputs into the error state, runs the three-mode heater control and
 * keeps the operating hours counter.
 * Assumes a single 100 MHz clock; measurement inputs come from logic on
 * the same clock, the aux pin comes from outside and is synchronised.
 */
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module sfhc_top
    import sfhc_pkg::*;
#(
    parameter int unsigned SEC_COUNT = SEC_CYCLES,
    parameter int unsigned FILL_WIDTH = 16,
    parameter int unsigned ANA_WIDTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [15:0] reg_rdata_o,
    // Measurement path
    input wire logic meas_valid_i,
    input wire logic [FILL_WIDTH-1:0] fill_count_i,
    input wire logic [FILL_WIDTH-1:0] fill_capacity_i,
    input wire logic signed [15:0] virt_temp_i,
    input wire logic [ANA_WIDTH-1:0] analog_value_i,
    input wire logic analog_enable_i,
    // Auxiliary digital pin, heater permit level
    input wire logic aux_digital_io_pin_i,
    // Outputs
    output logic heater_o,
    output logic [ANA_WIDTH-1:0] analog_o,
    output logic error_telegram_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0] aux_sync;
        logic [1:0] heater_mode_setting;
        logic error_analog_level_select;
        logic aux_pin_function_setting;
        logic [15:0] averaging_time_param;
        logic [31:0] sec_div;
        logic sec_tick;
        logic [7:0] stale_sec;
        logic [7:0] err_sec;
        logic [3:0] heat_off_sec;
        logic [11:0] hour_sec;
        logic [HOURS_WIDTH-1:0] hours;
        logic heat_request;
        logic heater;
        logic general_err;
        logic static_err;
        logic [ANA_WIDTH-1:0] analog_hold;
        logic [ANA_WIDTH-1:0] analog;
        logic telegram_err;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic [15:0] rdata;
    } sfhc_state_s;

    sfhc_state_s st;
    sfhc_state_s next_st;

    // Fill code: n when count above n/8 and at most (n+1)/8 of capacity
    function automatic logic [2:0] sfhc_fill_code(input logic [FILL_WIDTH-1:0] cnt,
                                                  input logic [FILL_WIDTH-1:0] cap);
        logic [FILL_WIDTH+2:0] c8;
        logic [2:0] code;
        c8 = {cnt, 3'h0};
        code = 3'h0;
        for (int n = 1; n < 8; n++) begin
            if (c8 > (FILL_WIDTH+3)'(cap) * (FILL_WIDTH+3)'(n)) begin
                code = 3'(n);
            end
        end
        return code;
    endfunction

    logic [2:0] fill_code;
    logic heat_criterion;
    logic heat_permit;
    logic [7:0] op_status;
    logic [7:0] err_status;
    logic [2:0] irq_events;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.aux_sync = {st.aux_sync[0], aux_digital_io_pin_i};

        // One-second tick
        next_st.sec_tick = 1'b0;
        if (st.sec_div >= SEC_COUNT - 1) begin
            next_st.sec_div = '0;
            next_st.sec_tick = 1'b1;
        end else begin
            next_st.sec_div = st.sec_div + 32'h1;
        end

        // Staleness in seconds since last valid measurement
        if (meas_valid_i) begin
            next_st.stale_sec = '0;
        end else if (st.sec_tick && st.stale_sec != 8'hff) begin
            next_st.stale_sec = st.stale_sec + 8'h1;
        end

        // General malfunction
        if (st.averaging_time_param < 16'(STALE_LIMIT_S)) begin
            next_st.general_err = (st.stale_sec >= 8'(STALE_LIMIT_S));
        end else begin
            // Count below half of averaging time, one value per second
            next_st.general_err = ({fill_count_i, 1'b0} <
                                   (FILL_WIDTH+1)'(st.averaging_time_param));
        end

        // Duration of continuous error in seconds
        if (!st.general_err) begin
            next_st.err_sec = '0;
        end else if (st.sec_tick && st.err_sec != 8'hff) begin
            next_st.err_sec = st.err_sec + 8'h1;
        end
        next_st.static_err = (st.err_sec > 8'(STATIC_FAULT_S));

        // Heater request with hysteresis
        if (heat_criterion) begin
            next_st.heat_request = 1'b1;
            next_st.heat_off_sec = '0;
        // Off delay runs only once warm and free of error, keeping the hysteresis
        end else if (st.heat_request && virt_temp_i > TEMP_OFF_LIMIT && !st.general_err) begin
            if (st.heat_off_sec >= 4'(HEAT_OFF_DELAY_S)) begin
                next_st.heat_request = 1'b0;
            end else if (st.sec_tick) begin
                next_st.heat_off_sec = st.heat_off_sec + 4'h1;
            end
        end else begin
            next_st.heat_off_sec = '0;
        end

        // Heater drive by mode
        case (sfhc_heat_mode_e'(st.heater_mode_setting))
            SFHC_HEAT_OFF: next_st.heater = 1'b0;
            SFHC_HEAT_ALWAYS: next_st.heater = heat_permit;
            SFHC_HEAT_AUTO: next_st.heater = st.heat_request && heat_permit;
            default: next_st.heater = 1'b0;
        endcase

        // Operating hours
        if (st.sec_tick) begin
            if (st.hour_sec >= 12'(HOUR_S - 1)) begin
                next_st.hour_sec = '0;
                // Wrap at the last five-digit count rather than the binary limit
                if (st.hours >= HOURS_MAX) begin
                    next_st.hours = '0;
                end else begin
                    next_st.hours = st.hours + 1'b1;
                end
            end else begin
                next_st.hour_sec = st.hour_sec + 12'h1;
            end
        end

        // Analog output: hold last value while stale, force level on error
        if (meas_valid_i) begin
            next_st.analog_hold = analog_value_i;
        end
        if (!analog_enable_i) begin
            next_st.analog = '0;
        end else if (st.general_err) begin
            next_st.analog = st.error_analog_level_select ? '1 : '0;
        end else begin
            next_st.analog = meas_valid_i ? analog_value_i : st.analog_hold;
        end
        next_st.telegram_err = st.general_err;

        // Interrupt events from the flags just computed above
        irq_events = 3'h0;
        irq_events[IRQ_GENERAL] = next_st.general_err && !st.general_err;
        irq_events[IRQ_STATIC] = next_st.static_err && !st.static_err;
        irq_events[IRQ_HEAT] = next_st.heater != st.heater;

        // Interrupts: set wins over clear
        next_st.irq_status = st.irq_status;
        if (reg_write_i && reg_addr_i == REG_IRQ_CLEAR) begin
            next_st.irq_status = st.irq_status & ~reg_wdata_i[2:0];
        end
        next_st.irq_status = next_st.irq_status | irq_events;

        // Register writes
        if (reg_write_i) begin
            case (reg_addr_i)
                REG_CONFIG: begin
                    next_st.heater_mode_setting = reg_wdata_i[CFG_MODE_LSB +: 2];
                    next_st.error_analog_level_select = reg_wdata_i[CFG_LEVEL_BIT];
                    next_st.aux_pin_function_setting = reg_wdata_i[CFG_AUX_BIT];
                end
                REG_AVG_TIME: next_st.averaging_time_param = reg_wdata_i;
                REG_IRQ_ENABLE: next_st.irq_enable = reg_wdata_i[2:0];
                default: next_st.rdata = st.rdata;
            endcase
        end

        // Register reads, data valid the next cycle
        next_st.rdata = '0;
        if (reg_read_i) begin
            case (reg_addr_i)
                REG_OP_STATUS: next_st.rdata = {8'h00, op_status};
                REG_ERR_STATUS: next_st.rdata = {8'h00, err_status};
                REG_CONFIG: next_st.rdata = {12'h000, st.aux_pin_function_setting,
                                             st.error_analog_level_select,
                                             st.heater_mode_setting};
                REG_AVG_TIME: next_st.rdata = st.averaging_time_param;
                REG_HOURS: next_st.rdata = st.hours[15:0];
                REG_IRQ_STATUS: next_st.rdata = {13'h0000, st.irq_status};
                REG_IRQ_ENABLE: next_st.rdata = {13'h0000, st.irq_enable};
                default: next_st.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode

    always_comb begin
        fill_code = sfhc_fill_code(fill_count_i, fill_capacity_i);
        heat_criterion = (virt_temp_i < TEMP_ON_LIMIT) ||
                         (st.err_sec > 8'(HEAT_ERR_ON_S));
        heat_permit = !st.aux_pin_function_setting || st.aux_sync[1];
        op_status = 8'h00;
        op_status[OP_FILL_LSB +: 3] = fill_code;
        op_status[OP_HEAT_CRIT] = heat_criterion &&
                                  (st.heater_mode_setting == HEATER_MODE_RESET);
        op_status[OP_HEAT_ON] = st.heater;
        err_status = 8'h00;
        err_status[ERR_GENERAL] = st.general_err;
        err_status[ERR_STATIC] = st.static_err;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
            st.heater_mode_setting <= HEATER_MODE_RESET;
            st.averaging_time_param <= AVG_TIME_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign reg_rdata_o = st.rdata;
    assign heater_o = st.heater;
    assign analog_o = st.analog;
    assign error_telegram_o = st.telegram_err;
    assign irq_o = |(st.irq_status & st.irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_heat_bit;
        @(posedge clock_i) disable iff (!reset_n_i)
        $past(reg_read_i && reg_addr_i == REG_OP_STATUS) |->
        reg_rdata_o[OP_HEAT_ON] == $past(heater_o);
    endproperty
    a_heat_bit: assert property (p_heat_bit) else $error("heat bit mismatch");

    property p_mode_off;
        @(posedge clock_i) disable iff (!reset_n_i)
        st.heater_mode_setting == 2'h0 |=> !heater_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("heater on in mode 0");

    property p_mode_on;
        @(posedge clock_i) disable iff (!reset_n_i)
        (st.heater_mode_setting == 2'h2 && heat_permit) |=> heater_o;
    endproperty
    a_mode_on: assert property (p_mode_on) else $error("heater off in mode 2");

    property p_permit;
        @(posedge clock_i) disable iff (!reset_n_i)
        !heat_permit |=> !heater_o;
    endproperty
    a_permit: assert property (p_permit) else $error("heater on while blocked");

    property p_reserved;
        @(posedge clock_i) disable iff (!reset_n_i)
        op_status[0] == 1'b0 && op_status[4] == 1'b0 && op_status[7] == 1'b0
        && err_status[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_stale;
        @(posedge clock_i) disable iff (!reset_n_i)
        (st.averaging_time_param < 16'h000a && st.stale_sec >= 8'h0a) |=> st.general_err;
    endproperty
    a_stale: assert property (p_stale) else $error("stale error missed");

    property p_analog_force;
        @(posedge clock_i) disable iff (!reset_n_i)
        (analog_enable_i && st.general_err) |=>
        analog_o == ($past(st.error_analog_level_select) ? {ANA_WIDTH{1'b1}} : {ANA_WIDTH{1'b0}});
    endproperty
    a_analog_force: assert property (p_analog_force) else $error("analog not forced");

    property p_hold;
        @(posedge clock_i) disable iff (!reset_n_i)
        (analog_enable_i && !st.general_err && !meas_valid_i) |=>
        analog_o == $past(st.analog_hold);
    endproperty
    a_hold: assert property (p_hold) else $error("analog not held");

    property p_general_long;
        @(posedge clock_i) disable iff (!reset_n_i)
        (st.averaging_time_param >= 16'(STALE_LIMIT_S) &&
         {fill_count_i, 1'b0} < (FILL_WIDTH+1)'(st.averaging_time_param)) |=> st.general_err;
    endproperty
    a_general_long: assert property (p_general_long) else $error("half buffer missed");

    property p_heat_crit;
        @(posedge clock_i) disable iff (!reset_n_i)
        $past(reg_read_i && reg_addr_i == REG_OP_STATUS && virt_temp_i < TEMP_ON_LIMIT
              && st.heater_mode_setting == 2'h1) |-> reg_rdata_o[OP_HEAT_CRIT];
    endproperty
    a_heat_crit: assert property (p_heat_crit) else $error("criterion bit missed");

    property p_off_delay;
        @(posedge clock_i) disable iff (!reset_n_i)
        $fell(st.heat_request) |-> $past(st.heat_off_sec) >= 4'(HEAT_OFF_DELAY_S);
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("heater off too soon");

    property p_irq_set;
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(st.general_err) |-> st.irq_status[IRQ_GENERAL];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("error event lost");

    property p_hours;
        @(posedge clock_i) disable iff (!reset_n_i)
        st.hours <= HOURS_MAX &&
        (!$changed(st.hours) || st.hours == '0 || st.hours == $past(st.hours) + 1'b1);
    endproperty
    a_hours: assert property (p_hours) else $error("hours counter jump");

    property p_telegram;
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(st.general_err) |=> error_telegram_o && err_status[ERR_GENERAL];
    endproperty
    a_telegram: assert property (p_telegram) else $error("error telegram late");

    property p_static;
        @(posedge clock_i) disable iff (!reset_n_i)
        st.static_err |-> st.err_sec > 8'h3c || $past(st.err_sec) > 8'h3c;
    endproperty
    a_static: assert property (p_static) else $error("static fault too early");

    c_heater_on: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(heater_o));
    c_general: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(st.general_err));
    c_irq: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(irq_o));
    c_static: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(st.static_err));

endmodule

// File: sfhc_pkg.sv
/*
 * Package for the status, fault and heating control block: register map,
 * field positions, reset values, heater modes and timing constants.
 * Assumes a 100 MHz system clock.
 */
package sfhc_pkg;

    // Clock
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;

    // Timing figures in their own units
    localparam int unsigned STALE_LIMIT_S = 10;
    localparam int unsigned STATIC_FAULT_S = 60;
    localparam int unsigned HEAT_ERR_ON_S = 3;
    localparam int unsigned HEAT_OFF_DELAY_S = 10;
    localparam int unsigned HOUR_S = 3600;

    // One second in clock cycles
    localparam int unsigned SEC_CYCLES = CLK_FREQ_HZ;

    // Operating hours counter wraps after about 11.4 years
    localparam int unsigned HOURS_WIDTH = 17;
    // Last count before the wrap, 99999 hours
    localparam logic [HOURS_WIDTH-1:0] HOURS_MAX = 17'h1869f;

    // Temperature limits in tenths of a degree C, signed
    localparam logic signed [15:0] TEMP_ON_LIMIT = 16'sh0014;
    localparam logic signed [15:0] TEMP_OFF_LIMIT = 16'sh0046;

    // Register offsets
    localparam logic [3:0] REG_OP_STATUS = 4'h0;
    localparam logic [3:0] REG_ERR_STATUS = 4'h1;
    localparam logic [3:0] REG_CONFIG = 4'h2;
    localparam logic [3:0] REG_AVG_TIME = 4'h3;
    localparam logic [3:0] REG_HOURS = 4'h4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h5;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h7;

    // Operating status field positions
    localparam int unsigned OP_FILL_LSB = 1;
    localparam int unsigned OP_HEAT_CRIT = 5;
    localparam int unsigned OP_HEAT_ON = 6;

    // Error status field positions
    localparam int unsigned ERR_GENERAL = 0;
    localparam int unsigned ERR_STATIC = 1;

    // Config register fields: [1:0] heater mode, [2] error level, [3] aux pin heater input
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_LEVEL_BIT = 2;
    localparam int unsigned CFG_AUX_BIT = 3;

    // Interrupt bits
    localparam int unsigned IRQ_GENERAL = 0;
    localparam int unsigned IRQ_STATIC = 1;
    localparam int unsigned IRQ_HEAT = 2;

    // Reset values
    localparam logic [1:0] HEATER_MODE_RESET = 2'h1;
    localparam logic [15:0] AVG_TIME_RESET = 16'h000a;

    // Heater modes
    typedef enum logic [1:0] {
        SFHC_HEAT_OFF,
        SFHC_HEAT_AUTO,
        SFHC_HEAT_ALWAYS
    } sfhc_heat_mode_e;

endpackage

// File: sfhc_meter_model.sv
/*
 * Measurement source beside the block: one valid pulse per second while
 * running, and the external heater permit level on the aux pin.
 * Assumes the block's clock; SEC sets the cycles in one second.
 */
`timescale 1ns/1ps
module sfhc_meter_model #(
    parameter int unsigned SEC = 10
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Control from the bench
    input wire logic run_i,
    input wire logic permit_i,
    // Lines into the block
    output logic meas_valid_o,
    output logic aux_o
);
    int unsigned cnt;

    ////////////////////////////////////////////////////////////////////////
    // One pulse per second; a stopped source sends no pulses but still passes the permit level
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 0;
            meas_valid_o <= 1'b0;
            aux_o <= 1'b0;
        end else begin
            cnt <= (cnt == SEC - 1) ? 0 : cnt + 1;
            meas_valid_o <= run_i && (cnt == 0);
            aux_o <= permit_i;
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the status, fault and heating block.
 * Assumes SEC_COUNT of 10 cycles and a buffer capacity of 64; the bench
 * drives the analog enable and the analog value itself.
 */
`timescale 1ns/1ps
module tb_top
    import sfhc_pkg::*;
;
    localparam int unsigned SEC = 10;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] fill = 16'h0040;
    logic signed [15:0] temp = 16'sh00c8;
    logic run = 1'b1;
    logic permit = 1'b1;
    logic pend = 1'b0;
    logic ana_en = 1'b1;
    logic [15:0] aval = 16'h1234;
    logic meas_valid, aux, heater, tele, irq;
    logic [15:0] rdata, ana;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h0000004b;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int mark = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #5 clock_i = ~clock_i;

    sfhc_top #(.SEC_COUNT(SEC)) dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .meas_valid_i(meas_valid), .fill_count_i(fill), .fill_capacity_i(16'h0040),
        .virt_temp_i(temp), .analog_value_i(aval), .analog_enable_i(ana_en),
        .aux_digital_io_pin_i(aux), .heater_o(heater), .analog_o(ana),
        .error_telegram_o(tele), .irq_o(irq));

    sfhc_meter_model #(.SEC(SEC)) meter (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(run), .permit_i(permit),
        .meas_valid_o(meas_valid), .aux_o(aux));

    ////////////////////////////////////////////////////////////////////////
    // Checking and bus tasks
    task automatic judge(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [15:0] got, input logic [31:0] note);
        judge(got & note[31:16], note[15:0]);
    endtask

    task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
        judge(got, exp);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    // Read strobe plus a note of the masked expectation
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({m, e & m});
        @(posedge clock_i);
        rd <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic wait_from(input int n);
        while (cyc - mark < n) @(posedge clock_i);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (pend) begin
            cmp_reg(rdata, exp_q.pop_front());
        end
        pend <= rd;
        cyc <= cyc + 1;
    end

    // Cut a hang short
    initial begin
        #(600_000);
        mismatches++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int c;
        idle(16);
        reset_n_i <= 1'b1;
        rd_reg(REG_CONFIG, 16'hffff, 16'h0001);
        rd_reg(REG_AVG_TIME, 16'hffff, 16'h000a);
        rd_reg(REG_HOURS, 16'hffff, 16'h0000);
        rd_reg(REG_ERR_STATUS, 16'hffff, 16'h0000);
        wr_reg(REG_OP_STATUS, 16'hffff);
        rd_reg(REG_OP_STATUS, 16'hff9f, 16'h000e);
        rd_reg(4'h8, 16'hffff, 16'h0000);
        // Random fill levels against the eighths code
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            c = int'(seed % 64) + 1;
            @(posedge clock_i) fill <= 16'(c);
            idle(3);
            rd_reg(REG_OP_STATUS, 16'hff9f, 16'((c * 8 - 1) / 64) << 1);
        end
        // Half-buffer fault, interrupt, static fault, forced outputs
        @(posedge clock_i) fill <= 16'h0040;
        wr_reg(REG_AVG_TIME, 16'h0014);
        wr_reg(REG_IRQ_CLEAR, 16'h0007);
        wr_reg(REG_IRQ_ENABLE, 16'h0001);
        @(posedge clock_i) fill <= 16'h000a;
        idle(4);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0000);
        @(posedge clock_i) fill <= 16'h0009;
        mark = cyc;
        idle(4);
        #1 cmp_pin(16'(irq), 16'h0001);
        cmp_pin(16'(tele), 16'h0001);
        cmp_pin(ana, 16'h0000);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0001);
        rd_reg(REG_IRQ_STATUS, 16'h0001, 16'h0001);
        wr_reg(REG_IRQ_ENABLE, 16'h0000);
        idle(1);
        #1 cmp_pin(16'(irq), 16'h0000);
        wr_reg(REG_IRQ_ENABLE, 16'h0001);
        wr_reg(REG_IRQ_CLEAR, 16'h0001);
        idle(1);
        #1 cmp_pin(16'(irq), 16'h0000);
        wait_from(550);
        rd_reg(REG_ERR_STATUS, 16'h0003, 16'h0001);
        wait_from(650);
        rd_reg(REG_ERR_STATUS, 16'h0003, 16'h0003);
        rd_reg(REG_OP_STATUS, 16'h0060, 16'h0060);
        #1 cmp_pin(16'(heater), 16'h0001);
        wr_reg(REG_CONFIG, 16'h0005);
        idle(3);
        #1 cmp_pin(ana, 16'hffff);
        // Disabled analog outputs are not forced
        @(posedge clock_i) ana_en <= 1'b0;
        idle(2);
        #1 cmp_pin(ana, 16'h0000);
        @(posedge clock_i) ana_en <= 1'b1;
        idle(2);
        #1 cmp_pin(ana, 16'hffff);
        // Fault ends, heater drops after the delay
        @(posedge clock_i) fill <= 16'h0040;
        mark = cyc;
        idle(4);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0000);
        #1 cmp_pin(16'(tele), 16'h0000);
        cmp_pin(ana, 16'h1234);
        rd_reg(REG_OP_STATUS, 16'h0020, 16'h0000);
        wait_from(50);
        #1 cmp_pin(16'(heater), 16'h0001);
        wait_from(150);
        #1 cmp_pin(16'(heater), 16'h0000);
        // Stale measurements with short averaging
        wr_reg(REG_AVG_TIME, 16'h0005);
        @(posedge clock_i) run <= 1'b0;
        mark = cyc;
        idle(12);
        aval <= 16'h5678;
        wait_from(80);
        #1 cmp_pin(ana, 16'h1234);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0000);
        wait_from(125);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0001);
        #1 cmp_pin(16'(tele), 16'h0001);
        @(posedge clock_i) run <= 1'b1;
        idle(SEC + 4);
        rd_reg(REG_ERR_STATUS, 16'h0001, 16'h0000);
        #1 cmp_pin(ana, 16'h5678);
        // Cold start and warm-up delay
        @(posedge clock_i) temp <= 16'sh000a;
        idle(4);
        rd_reg(REG_OP_STATUS, 16'h0020, 16'h0020);
        idle(2);
        #1 cmp_pin(16'(heater), 16'h0001);
        @(posedge clock_i) temp <= 16'sh0064;
        mark = cyc;
        wait_from(50);
        #1 cmp_pin(16'(heater), 16'h0001);
        wait_from(150);
        #1 cmp_pin(16'(heater), 16'h0000);
        rd_reg(REG_OP_STATUS, 16'h0060, 16'h0000);
        // Fixed modes and the aux permit level
        @(posedge clock_i) temp <= 16'sh000a;
        wr_reg(REG_CONFIG, 16'h0000);
        idle(3);
        #1 cmp_pin(16'(heater), 16'h0000);
        @(posedge clock_i) temp <= 16'sh00c8;
        wr_reg(REG_CONFIG, 16'h0002);
        idle(3);
        #1 cmp_pin(16'(heater), 16'h0001);
        wr_reg(REG_CONFIG, 16'h000a);
        @(posedge clock_i) permit <= 1'b0;
        idle(6);
        #1 cmp_pin(16'(heater), 16'h0000);
        rd_reg(REG_OP_STATUS, 16'h0040, 16'h0000);
        @(posedge clock_i) permit <= 1'b1;
        idle(6);
        #1 cmp_pin(16'(heater), 16'h0001);
        wr_reg(REG_CONFIG, 16'h0003);
        idle(3);
        #1 cmp_pin(16'(heater), 16'h0000);
        // One hour of running
        while (cyc < 37100) @(posedge clock_i);
        rd_reg(REG_HOURS, 16'hffff, 16'h0001);
        idle(3);
        wrap_up();
    end
endmodule
